/* File: wssel_pkg.sv */
// Constants, field layout and types shared by the shutdown-state / source-select block
package wssel_pkg;
   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;
   localparam int DBAND_W = 8;

   // Register offsets
   localparam logic [ADDR_W-1:0] OFS_CTRL     = 3'h0;
   localparam logic [ADDR_W-1:0] OFS_STATUS   = 3'h1;
   localparam logic [ADDR_W-1:0] OFS_CONFIG   = 3'h2;
   localparam logic [ADDR_W-1:0] OFS_DBAND    = 3'h3;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 3'h4;
   localparam logic [ADDR_W-1:0] OFS_IRQ_CLR  = 3'h5;
   localparam logic [ADDR_W-1:0] OFS_IRQ_EN   = 3'h6;

   // Control register fields
   localparam int CTRL_LVLB_LSB = 6;
   localparam int CTRL_LVLA_LSB = 4;
   localparam int CTRL_SRC_LSB  = 0;
   localparam int CTRL_NC_BIT   = 3;
   localparam logic [DATA_W-1:0] CTRL_WMASK = 8'hf7;
   localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;

   // Other registers
   localparam int STAT_SHUT_BIT = 0;
   localparam int CFG_POLA_BIT  = 0;
   localparam int CFG_POLB_BIT  = 1;
   localparam logic [1:0] CFG_RESET = 2'h0;
   localparam logic [DBAND_W-1:0] DBAND_RESET = 8'h00;

   // Interrupt bits
   localparam int IRQ_W     = 3;
   localparam int IRQ_ENTER = 0;
   localparam int IRQ_LEAVE = 1;
   localparam int IRQ_RSVD  = 2;
   localparam logic [IRQ_W-1:0] IRQ_RESET = 3'h0;

   typedef enum logic [1:0] {
      LVL_DBAND = 2'h0,
      LVL_TRI   = 2'h1,
      LVL_LOW   = 2'h2,
      LVL_HIGH  = 2'h3
   } wssel_lvl_t;

   typedef enum logic [2:0] {
      SRC_CMP1 = 3'h0,
      SRC_CMP2 = 3'h1,
      SRC_PWM1 = 3'h2,
      SRC_PWM2 = 3'h3,
      SRC_PWM3 = 3'h4,
      SRC_PWM4 = 3'h5,
      SRC_PIN  = 3'h6,
      SRC_RSVD = 3'h7
   } wssel_src_t;

   typedef enum logic [2:0] {
      ST_RUN   = 3'h1,
      ST_DBAND = 3'h2,
      ST_SHUT  = 3'h4
   } wssel_state_t;
endpackage

/* File: wssel_dbcnt.sv */
// Down counter timing the dead-band interval before the inactive level
module wssel_dbcnt #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic             ce,
   input  wire logic             load,
   input  wire logic [WIDTH-1:0] loadValue,
   output logic                  done
);
   logic [WIDTH-1:0] count_q;
   logic [WIDTH-1:0] count_d;

   // Load wins; otherwise count down and hold at zero
   always_comb begin
      count_d = count_q;
      if (load) begin
         count_d = loadValue;
      end else if (count_q != '0) begin
         count_d = count_q - WIDTH'(1);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         count_q <= '0;
      end else if (ce) begin
         count_q <= count_d;
      end
   end

   assign done = (count_q == '0) && !load;
endmodule

/* File: wssel_top.sv */
// Shutdown output levels and waveform input source selection with register port
module wssel_top
   import wssel_pkg::*;
(
   input  wire logic              clk,
   input  wire logic              rst_n,
   input  wire logic              ce,
   input  wire logic [ADDR_W-1:0] regAddr,
   input  wire logic [DATA_W-1:0] regWData,
   input  wire logic              regWr,
   input  wire logic              regRd,
   output logic [DATA_W-1:0]      regRData,
   input  wire logic              shutdownEvent,
   input  wire logic              waveA,
   input  wire logic              waveB,
   input  wire logic              externalInput,
   input  wire logic              pwmChannel1Output,
   input  wire logic              pwmChannel2Output,
   input  wire logic              pwmChannel3Output,
   input  wire logic              pwmChannel4Output,
   input  wire logic              comparator1SyncedOutput,
   input  wire logic              comparator2SyncedOutput,
   output logic                   selectedInput,
   output logic                   outputA,
   output logic                   outputAOe,
   output logic                   outputB,
   output logic                   outputBOe,
   output logic                   irq
);
   // Pin level for one output: returns {enable, level}
   function automatic logic [1:0] levelDrive(input logic [1:0] lvl, input logic shut,
                                             input logic settled, input logic normal,
                                             input logic pol);
      logic [1:0] r;
      r = {1'b1, normal};
      if (shut) begin
         case (lvl)
            LVL_HIGH: r = 2'b11;
            LVL_LOW:  r = 2'b10;
            LVL_TRI:  r = 2'b00;
            default:  r = settled ? {1'b1, pol} : {1'b1, normal};
         endcase
      end
      return r;
   endfunction

   logic [DATA_W-1:0] ctrl_q, ctrl_d;
   logic [1:0]        cfg_q, cfg_d;
   logic [DBAND_W-1:0] dband_q, dband_d;
   logic [IRQ_W-1:0]  irqStat_q, irqStat_d;
   logic [IRQ_W-1:0]  irqEn_q, irqEn_d;
   logic [DATA_W-1:0] rdata_q, rdata_d;
   logic              shutActive_q;
   logic              selIn_q, selIn_d;
   wssel_state_t      state_q, state_d;
   logic              dbLoad;
   logic              dbDone;
   logic [1:0]        outOe_q, outOe_d;
   logic [1:0]        outLvl_q, outLvl_d;
   logic [1:0][1:0]   lvlSel;
   logic [1:0]        polSel;
   logic [1:0]        normSel;
   logic [IRQ_W-1:0]  irqSet;
   logic [IRQ_W-1:0]  irqClr;
   logic              wrCtrl;

   // Field views per output, index 0 is A and 1 is B
   assign lvlSel[0]  = ctrl_q[CTRL_LVLA_LSB +: 2];
   assign lvlSel[1]  = ctrl_q[CTRL_LVLB_LSB +: 2];
   assign polSel[0]  = cfg_q[CFG_POLA_BIT];
   assign polSel[1]  = cfg_q[CFG_POLB_BIT];
   assign normSel[0] = waveA ^ polSel[0];
   assign normSel[1] = waveB ^ polSel[1];
   assign wrCtrl     = regWr && (regAddr == OFS_CTRL);

   // Register writes; interrupt set beats a clear in the same cycle
   always_comb begin
      ctrl_d  = ctrl_q;
      cfg_d   = cfg_q;
      dband_d = dband_q;
      irqEn_d = irqEn_q;
      irqClr  = '0;
      if (regWr) begin
         case (regAddr)
            OFS_CTRL:    ctrl_d  = regWData & CTRL_WMASK;
            OFS_CONFIG:  cfg_d   = regWData[1:0];
            OFS_DBAND:   dband_d = regWData;
            OFS_IRQ_CLR: irqClr  = regWData[IRQ_W-1:0];
            OFS_IRQ_EN:  irqEn_d = regWData[IRQ_W-1:0];
            default:     ctrl_d  = ctrl_q;
         endcase
      end
      irqSet = '0;
      irqSet[IRQ_ENTER] = shutdownEvent && !shutActive_q;
      irqSet[IRQ_LEAVE] = !shutdownEvent && shutActive_q;
      // Reserved encoding is kept but flagged, since it has no source
      irqSet[IRQ_RSVD]  = wrCtrl && (regWData[CTRL_SRC_LSB +: 3] == SRC_RSVD);
      irqStat_d = (irqStat_q & ~irqClr) | irqSet;
   end

   // Registered read data, valid only the cycle after the strobe
   always_comb begin
      rdata_d = '0;
      if (regRd) begin
         case (regAddr)
            OFS_CTRL:     rdata_d = ctrl_q & CTRL_WMASK;
            OFS_STATUS:   rdata_d[STAT_SHUT_BIT] = shutActive_q;
            OFS_CONFIG:   rdata_d[1:0] = cfg_q;
            OFS_DBAND:    rdata_d = dband_q;
            OFS_IRQ_STAT: rdata_d[IRQ_W-1:0] = irqStat_q;
            OFS_IRQ_EN:   rdata_d[IRQ_W-1:0] = irqEn_q;
            default:      rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q       <= CTRL_RESET;
         cfg_q        <= CFG_RESET;
         dband_q      <= DBAND_RESET;
         irqStat_q    <= IRQ_RESET;
         irqEn_q      <= IRQ_RESET;
         rdata_q      <= '0;
         shutActive_q <= 1'b0;
      end else if (ce) begin
         ctrl_q       <= ctrl_d;
         cfg_q        <= cfg_d;
         dband_q      <= dband_d;
         irqStat_q    <= irqStat_d;
         irqEn_q      <= irqEn_d;
         rdata_q      <= rdata_d;
         shutActive_q <= shutdownEvent;
      end
   end

   // Input source mux; reserved code yields a quiet low
   always_comb begin
      case (ctrl_q[CTRL_SRC_LSB +: 3])
         SRC_CMP1: selIn_d = comparator1SyncedOutput;
         SRC_CMP2: selIn_d = comparator2SyncedOutput;
         SRC_PWM1: selIn_d = pwmChannel1Output;
         SRC_PWM2: selIn_d = pwmChannel2Output;
         SRC_PWM3: selIn_d = pwmChannel3Output;
         SRC_PWM4: selIn_d = pwmChannel4Output;
         SRC_PIN:  selIn_d = externalInput;
         default:  selIn_d = 1'b0;
      endcase
   end

   // Dead-band sequencing on entry to shutdown
   always_comb begin
      state_d = state_q;
      dbLoad  = 1'b0;
      case (state_q)
         ST_RUN: begin
            if (shutActive_q) begin
               state_d = ST_DBAND;
               dbLoad  = 1'b1;
            end
         end
         ST_DBAND: begin
            if (!shutActive_q) begin
               state_d = ST_RUN;
            end else if (dbDone) begin
               state_d = ST_SHUT;
            end
         end
         ST_SHUT: begin
            if (!shutActive_q) begin
               state_d = ST_RUN;
            end
         end
         default: state_d = ST_RUN;
      endcase
   end

   wssel_dbcnt #(
      .WIDTH (DBAND_W)
   ) u_dbcnt (
      .clk       (clk),
      .rst_n     (rst_n),
      .ce        (ce),
      .load      (dbLoad),
      .loadValue (dband_q),
      .done      (dbDone)
   );

   // Same drive decision for both outputs
   for (genvar i = 0; i < 2; i++) begin : g_out
      logic [1:0] drv;
      // Forced overrides gated by the shutdown status; the dead-band level also waits for state ST_SHUT
      assign drv = levelDrive(lvlSel[i], shutActive_q, state_q == ST_SHUT,
                              normSel[i], polSel[i]);
      assign outOe_d[i]  = drv[1];
      assign outLvl_d[i] = drv[0];
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q  <= ST_RUN;
         selIn_q  <= 1'b0;
         outOe_q  <= 2'b11;
         outLvl_q <= 2'b00;
      end else if (ce) begin
         state_q  <= state_d;
         selIn_q  <= selIn_d;
         outOe_q  <= outOe_d;
         outLvl_q <= outLvl_d;
      end
   end

   assign regRData      = rdata_q;
   assign selectedInput = selIn_q;
   assign outputA       = outLvl_q[0];
   assign outputAOe     = outOe_q[0];
   assign outputB       = outLvl_q[1];
   assign outputBOe     = outOe_q[1];
   assign irq           = |(irqStat_q & irqEn_q);

   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   sequence s_shutRise;
      ce && !shutActive_q ##1 ce && shutActive_q && state_q == ST_RUN;
   endsequence

   property p_force_b;
      ce && shutActive_q && lvlSel[1] == LVL_HIGH |=> outputB && outputBOe;
   endproperty
   a_force_b: assert property (p_force_b) else $error("B not forced high");

   property p_tri_b;
      ce && shutActive_q && lvlSel[1] == LVL_TRI |=> !outputBOe;
   endproperty
   a_tri_b: assert property (p_tri_b) else $error("B not released");

   property p_dband_enter;
      s_shutRise |=> state_q == ST_DBAND;
   endproperty
   a_dband_enter: assert property (p_dband_enter) else $error("No dead-band");

   property p_force_a_low;
      ce && shutActive_q && lvlSel[0] == LVL_LOW |=> !outputA && outputAOe;
   endproperty
   a_force_a_low: assert property (p_force_a_low) else $error("A not forced low");

   property p_settled_a;
      ce && state_q == ST_SHUT && shutActive_q && lvlSel[0] == LVL_DBAND
         |=> outputAOe && outputA == $past(polSel[0]);
   endproperty
   a_settled_a: assert property (p_settled_a) else $error("A wrong idle level");

   property p_no_override;
      ce && !shutActive_q |=> outputAOe && outputBOe && outputA == $past(normSel[0]);
   endproperty
   a_no_override: assert property (p_no_override) else $error("Override outside");

   property p_bit3;
      ce && regRd && regAddr == OFS_CTRL |=> !regRData[CTRL_NC_BIT];
   endproperty
   a_bit3: assert property (p_bit3) else $error("Bit 3 read nonzero");

   property p_src_pin;
      ce && ctrl_q[CTRL_SRC_LSB +: 3] == SRC_PIN |=> selectedInput == $past(externalInput);
   endproperty
   a_src_pin: assert property (p_src_pin) else $error("Pin source wrong");

   property p_src_cmp1;
      ce && ctrl_q[CTRL_SRC_LSB +: 3] == SRC_CMP1
         |=> selectedInput == $past(comparator1SyncedOutput);
   endproperty
   a_src_cmp1: assert property (p_src_cmp1) else $error("Comparator 1 wrong");

   property p_status;
      ce && regRd && regAddr == OFS_STATUS |=> regRData[STAT_SHUT_BIT] == $past(shutActive_q);
   endproperty
   a_status: assert property (p_status) else $error("Status wrong");

   property p_src_cmp2;
      ce && ctrl_q[CTRL_SRC_LSB +: 3] == SRC_CMP2
         |=> selectedInput == $past(comparator2SyncedOutput);
   endproperty
   a_src_cmp2: assert property (p_src_cmp2) else $error("Comparator 2 wrong");
endmodule

/* File: wssel_stage_model.sv */
// Power stage model: gate inputs fed by the two block outputs
module wssel_stage_model (
   input  wire logic outputA,
   input  wire logic outputAOe,
   input  wire logic outputB,
   input  wire logic outputBOe,
   output logic      gateA,
   output logic      gateB
);
   timeunit 1ns;
   timeprecision 1ns;

   // Gate inputs carry pull-downs, so a released pin settles low
   assign gateA = outputAOe ? outputA : 1'b0;
   assign gateB = outputBOe ? outputB : 1'b0;
endmodule

/* File: waveform_shutdown_state_select_tb.sv */
// Self-checking bench for shutdown levels and input source selection
module waveform_shutdown_state_select_tb
   import wssel_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic              clk = 1'b0;
   logic              rst_n = 1'b0;
   logic              ce = 1'b1;
   logic [ADDR_W-1:0] regAddr = '0;
   logic [DATA_W-1:0] regWData = '0;
   logic              regWr = 1'b0;
   logic              regRd = 1'b0;
   logic [DATA_W-1:0] regRData;
   logic              shutdownEvent = 1'b0;
   logic              waveA = 1'b0;
   logic              waveB = 1'b0;
   logic [6:0]        srcIn = '0;
   logic              selectedInput;
   logic              outputA;
   logic              outputAOe;
   logic              outputB;
   logic              outputBOe;
   logic              irq;
   logic              gateA;
   logic              gateB;
   logic              rdPrev = 1'b0;
   logic [DATA_W-1:0] expQ[$];
   int                err_total = 0;
   int                checks_done = 0;

   // Source inputs indexed by their select code
   wssel_top uut (
      .clk(clk), .rst_n(rst_n), .ce(ce), .regAddr(regAddr), .regWData(regWData),
      .regWr(regWr), .regRd(regRd), .regRData(regRData), .shutdownEvent(shutdownEvent),
      .waveA(waveA), .waveB(waveB), .externalInput(srcIn[6]),
      .pwmChannel1Output(srcIn[2]), .pwmChannel2Output(srcIn[3]),
      .pwmChannel3Output(srcIn[4]), .pwmChannel4Output(srcIn[5]),
      .comparator1SyncedOutput(srcIn[0]), .comparator2SyncedOutput(srcIn[1]),
      .selectedInput(selectedInput), .outputA(outputA), .outputAOe(outputAOe),
      .outputB(outputB), .outputBOe(outputBOe), .irq(irq)
   );

   wssel_stage_model stage (
      .outputA(outputA), .outputAOe(outputAOe), .outputB(outputB),
      .outputBOe(outputBOe), .gateA(gateA), .gateB(gateB)
   );

   // Clock at 50 ns period
   always #25 clk = ~clk;

   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic cyc(int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
      @(posedge clk);
      regWr    <= 1'b1;
      regAddr  <= a;
      regWData <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask

   // Expected read data is queued; the monitor below consumes it
   task automatic rd(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e);
      expQ.push_back(e);
      @(posedge clk);
      regRd   <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
   endtask

   // Pin levels seen by the stage and drive enables, A then B
   task automatic pins(logic [3:0] e);
      @(negedge clk);
      chk("pins", {4'h0, gateA, outputAOe, gateB, outputBOe}, {4'h0, e});
   endtask

   task automatic irqIs(logic e);
      @(negedge clk);
      chk("irq", {7'h0, irq}, {7'h0, e});
   endtask

   // Forced level code to {pin, enable}; a released pin reads low
   function automatic logic [1:0] lvl(logic [1:0] c);
      return {c == 2'h3, c != 2'h1};
   endfunction

   // Read data stand only in the cycle after the strobe edge
   always @(posedge clk) rdPrev <= regRd & ce;
   always @(negedge clk) begin
      if (rdPrev) begin
         if (expQ.size() == 0) chk("unexpected read", 8'h01, 8'h00);
         else chk("read data", regRData, expQ.pop_front());
      end
   end

   // Watchdog well beyond the expected run of a few hundred cycles
   initial begin
      cyc(4000);
      err_total++;
      end_sim();
   end

   initial begin
      logic [7:0] d;
      logic [1:0] lb;
      void'($urandom(92303));
      cyc(5);
      rst_n <= 1'b1;
      rd(OFS_CTRL, 8'h00);
      rd(OFS_STATUS, 8'h00);
      rd(3'h7, 8'h00);
      pins(4'h5);
      $display("test reset done");
      // Bit 3 never sticks; code 111 is kept out
      for (int i = 0; i < 4; i++) begin
         d = 8'($urandom) | 8'h08;
         if (d[2:0] == 3'h7) d[0] = 1'b0;
         wr(OFS_CTRL, d);
         rd(OFS_CTRL, d & 8'hf7);
      end
      $display("test unused bit done");
      for (int c = 0; c < 7; c++) begin
         wr(OFS_CTRL, 8'(c));
         repeat (2) begin
            @(posedge clk);
            srcIn <= 7'($urandom);
            cyc(2);
            @(negedge clk);
            chk("source", {7'h0, selectedInput}, {7'h0, srcIn[c]});
         end
      end
      $display("test source select done");
      // Forced levels ignore random polarity and waveform
      for (int l = 1; l < 4; l++) begin
         lb = 2'((l % 3) + 1);
         wr(OFS_CONFIG, 8'($urandom) & 8'h03);
         wr(OFS_CTRL, {lb, 2'(l), 4'h6});
         @(posedge clk);
         shutdownEvent <= 1'b1;
         waveA <= 1'($urandom);
         waveB <= 1'($urandom);
         cyc(3);
         pins({lvl(2'(l)), lvl(lb)});
         rd(OFS_STATUS, 8'h01);
         @(posedge clk);
         shutdownEvent <= 1'b0;
         cyc(3);
         rd(OFS_STATUS, 8'h00);
      end
      $display("test forced levels done");
      // Forced codes must stay idle without shutdown
      wr(OFS_CONFIG, 8'h01);
      wr(OFS_CTRL, 8'hf6);
      @(posedge clk);
      waveA <= 1'b1;
      waveB <= 1'b1;
      cyc(2);
      pins(4'h7);
      $display("test idle override done");
      wr(OFS_IRQ_CLR, 8'h07);
      wr(OFS_IRQ_EN, 8'h01);
      rd(OFS_IRQ_STAT, 8'h00);
      wr(OFS_DBAND, 8'h03);
      wr(OFS_CTRL, 8'h06);
      @(posedge clk);
      shutdownEvent <= 1'b1;
      // Status lands one edge after the event; the count of three then runs
      // and the inactive level shows one edge after the state reaches SHUT
      cyc(6);
      pins(4'h7);
      cyc(1);
      pins(4'hd);
      irqIs(1'b1);
      rd(OFS_IRQ_STAT, 8'h01);
      @(posedge clk);
      shutdownEvent <= 1'b0;
      cyc(3);
      pins(4'h7);
      rd(OFS_IRQ_STAT, 8'h03);
      wr(OFS_IRQ_EN, 8'h00);
      irqIs(1'b0);
      wr(OFS_IRQ_CLR, 8'h03);
      wr(OFS_IRQ_EN, 8'h03);
      rd(OFS_IRQ_STAT, 8'h00);
      irqIs(1'b0);
      $display("test dead band and interrupt done");
      // Strobes with the clock enable low are dropped
      @(posedge clk);
      ce <= 1'b0;
      wr(OFS_DBAND, 8'h55);
      ce <= 1'b1;
      rd(OFS_DBAND, 8'h03);
      cyc(2);
      $display("test clock enable done");
      end_sim();
   end
endmodule
